// *** include/tcr_pkg.sv ***
// Purpose: constants for the transmit control and hardware setup registers
// Assumes: byte offsets on an 8-bit host address, 32-bit data words
// Notes: sizes are in bytes, allocation field in 1KB units
// What this block does
// - writing one to bit 15 clears transmit status fifo pointers, self-clearing
// - writing one to bit 14 clears transmit data fifo pointers, self-clearing
// - with overrun-allow clear, a full status fifo suspends transmission
// - with overrun-allow set, transmission continues on a full status fifo
// - status full event is raised regardless of overrun-allow
// - transmit enable set makes the transmitter run and send data
// - transmit enable clears itself after a requested stop has completed
// - stop request lets the current frame finish, then clears itself
// - host writes to the stop bit are ignored while it reads high
// - allocation field bits 19:16 gives transmit space in KB, reset five
// - status fifo takes 512 bytes, data fifo takes the rest
// - transmit data fifo holds both commands and packet data
// - receive fifos take 16KB minus the transmit allocation
// - clock select bits 6:5, reset 00, choose the mii clock source
// - 00 and 11 internal, 01 external port, 10 clocks disabled
// - clock select steers only the mii clocks, nothing else
`default_nettype none
package tcr_pkg;
  localparam logic [7:0] TCR_OFS_TX_CTL = 8'h70;
  localparam logic [7:0] TCR_OFS_HW_SETUP = 8'h74;
  localparam int TCR_BIT_STS_FLUSH = 15;
  localparam int TCR_BIT_DATA_FLUSH = 14;
  localparam int TCR_BIT_SAO = 2;
  localparam int TCR_BIT_TX_ON = 1;
  localparam int TCR_BIT_STOP = 0;
  localparam int TCR_BIT_MUST_SET = 20;
  localparam int TCR_ALLOC_LSB = 16;
  localparam int TCR_CLKSEL_LSB = 5;
  localparam logic [3:0] TCR_ALLOC_RST = 4'h5;
  localparam logic [1:0] TCR_CLKSEL_RST = 2'h0;
  localparam logic [14:0] TCR_STATUS_BYTES = 15'h0200;
  localparam logic [14:0] TCR_TOTAL_BYTES = 15'h4000;
  // sizes that the reset allocation of five gives
  localparam logic [14:0] TCR_TX_DATA_RST = 15'h1200;
  localparam logic [14:0] TCR_RX_BYTES_RST = 15'h2c00;
  // one-hot clock source: bit0 internal, bit1 external, bit2 disabled
  localparam logic [2:0] TCR_CLK_INTERNAL = 3'h1;
  localparam logic [2:0] TCR_CLK_EXTERNAL = 3'h2;
  localparam logic [2:0] TCR_CLK_OFF = 3'h4;
endpackage
`default_nettype wire

// *** include/tcr_ctl_if.sv ***
// Purpose: control signals between register bank and transmit gate
// Assumes: all on sys_clk
// Notes: stop_done is combinational from the gate
`timescale 1ns/10ps
`default_nettype none
interface tcr_ctl_if;
  logic tx_on;
  logic sao;
  logic stop;
  logic status_full;
  logic halted;
  logic run;
  logic stop_done;
  modport regs (output tx_on, output sao, output stop, output status_full, output halted,
                input run, input stop_done);
  modport gate (input tx_on, input sao, input stop, input status_full, input halted,
                output run, output stop_done);
endinterface
`default_nettype wire

// *** hdl/tcr_tx_gate.sv ***
// Purpose: transmitter run gating and stop completion
// Assumes: halted and status_full come from sys_clk logic
// Notes: run is registered, one cycle behind its causes
`timescale 1ns/10ps
`default_nettype none
module tcr_tx_gate (
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // control
  tcr_ctl_if.gate ctl
);
  logic run_r;
  logic run_nxt;

  assign ctl.stop_done = ctl.stop && ctl.halted;
  assign ctl.run = run_r;

  always_comb
  begin
    run_nxt = ctl.tx_on && !ctl.stop_done && !(ctl.status_full && !ctl.sao);
  end

  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
      run_r <= 1'b0;
    else
      run_r <= run_nxt;
  end

  property p_suspend_full;
    @(posedge sys_clk) disable iff (reset)
    (ctl.status_full && !ctl.sao) |=> !ctl.run;
  endproperty
  a_suspend_full: assert property (p_suspend_full) else $error("run high with full status fifo");

  property p_overrun_allowed;
    @(posedge sys_clk) disable iff (reset)
    (ctl.tx_on && ctl.sao && !ctl.stop) |=> ctl.run;
  endproperty
  a_overrun_allowed: assert property (p_overrun_allowed) else $error("run dropped with overrun allowed");

  property p_enable_runs;
    @(posedge sys_clk) disable iff (reset)
    (ctl.tx_on && !ctl.stop && !ctl.status_full) |=> ctl.run;
  endproperty
  a_enable_runs: assert property (p_enable_runs) else $error("enabled transmitter not running");

  property p_off_stops;
    @(posedge sys_clk) disable iff (reset)
    !ctl.tx_on |=> !ctl.run;
  endproperty
  a_off_stops: assert property (p_off_stops) else $error("run high while disabled");
endmodule
`default_nettype wire

// *** hdl/tcr_regs.sv ***
// Purpose: transmit control and hardware setup register bank
// Assumes: host strobes are synchronous to sys_clk, one cycle each
// Notes: read data valid one edge after rd_en
`timescale 1ns/10ps
`default_nettype none
module tcr_regs (
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // host register port
  input wire logic [7:0] host_addr,
  input wire logic host_wr_en,
  input wire logic host_rd_en,
  input wire logic [31:0] host_wr_data,
  output logic [31:0] host_rd_data,
  // transmitter side
  input wire logic tx_status_fifo_full,
  input wire logic tx_halted,
  output logic tx_run,
  output logic tx_stop_req,
  output logic tx_status_flush,
  output logic tx_data_flush,
  output logic status_full_event,
  // fifo memory split
  output logic [14:0] tx_data_bytes,
  output logic [14:0] rx_bytes,
  // configuration
  output logic must_set_bit,
  output logic [2:0] mii_clock_source
);
  logic sts_flush_r, sts_flush_nxt;
  logic data_flush_r, data_flush_nxt;
  logic sao_r, sao_nxt;
  logic tx_on_r, tx_on_nxt;
  logic stop_r, stop_nxt;
  logic must_set_r, must_set_nxt;
  logic [3:0] alloc_r, alloc_nxt;
  logic [1:0] clksel_r, clksel_nxt;
  logic [2:0] clk_src_r, clk_src_nxt;
  logic [14:0] tx_data_bytes_r, tx_data_bytes_nxt;
  logic [14:0] rx_bytes_r, rx_bytes_nxt;
  logic full_evt_r, full_evt_nxt;
  logic [31:0] rd_data_r, rd_data_nxt;
  logic ctl_wr;
  logic hw_wr;

  tcr_ctl_if ctl ();

  function automatic logic [14:0] kb_bytes(input logic [3:0] kb);
    return {1'b0, kb, 10'h000};
  endfunction

  function automatic logic [2:0] clk_decode(input logic [1:0] sel);
    logic [2:0] src;
    src = tcr_pkg::TCR_CLK_INTERNAL;
    unique case (sel)
      2'h1: src = tcr_pkg::TCR_CLK_EXTERNAL;
      2'h2: src = tcr_pkg::TCR_CLK_OFF;
      2'h0, 2'h3: src = tcr_pkg::TCR_CLK_INTERNAL;
    endcase
    return src;
  endfunction

  assign ctl_wr = host_wr_en && (host_addr == tcr_pkg::TCR_OFS_TX_CTL);
  assign hw_wr = host_wr_en && (host_addr == tcr_pkg::TCR_OFS_HW_SETUP);

  assign ctl.tx_on = tx_on_r;
  assign ctl.sao = sao_r;
  assign ctl.stop = stop_r;
  assign ctl.status_full = tx_status_fifo_full;
  assign ctl.halted = tx_halted;

  tcr_tx_gate u_gate (
    .sys_clk (sys_clk),
    .reset (reset),
    .ctl (ctl.gate)
  );

  always_comb
  begin
    sts_flush_nxt = ctl_wr && host_wr_data[tcr_pkg::TCR_BIT_STS_FLUSH];
    data_flush_nxt = ctl_wr && host_wr_data[tcr_pkg::TCR_BIT_DATA_FLUSH];
    sao_nxt = ctl_wr ? host_wr_data[tcr_pkg::TCR_BIT_SAO] : sao_r;
    tx_on_nxt = tx_on_r;
    stop_nxt = stop_r;
    if (ctl.stop_done)
    begin
      tx_on_nxt = 1'b0;
      stop_nxt = 1'b0;
    end
    if (ctl_wr)
    begin
      tx_on_nxt = host_wr_data[tcr_pkg::TCR_BIT_TX_ON];
      if (!stop_r && host_wr_data[tcr_pkg::TCR_BIT_STOP])
        stop_nxt = 1'b1;
    end
    full_evt_nxt = tx_status_fifo_full;
  end

  always_comb
  begin
    // no interlock here; the host keeps tx and rx halted around these writes
    must_set_nxt = must_set_r;
    alloc_nxt = alloc_r;
    clksel_nxt = clksel_r;
    if (hw_wr)
    begin
      must_set_nxt = host_wr_data[tcr_pkg::TCR_BIT_MUST_SET];
      alloc_nxt = host_wr_data[tcr_pkg::TCR_ALLOC_LSB +: 4];
      clksel_nxt = host_wr_data[tcr_pkg::TCR_CLKSEL_LSB +: 2];
    end
    // data fifo gets remainder, commands share it
    tx_data_bytes_nxt = kb_bytes(alloc_r) - tcr_pkg::TCR_STATUS_BYTES;
    rx_bytes_nxt = tcr_pkg::TCR_TOTAL_BYTES - kb_bytes(alloc_r);
    clk_src_nxt = clk_decode(clksel_r);
  end

  always_comb
  begin
    rd_data_nxt = rd_data_r;
    if (host_rd_en)
    begin
      rd_data_nxt = 32'h0000_0000;
      if (host_addr == tcr_pkg::TCR_OFS_TX_CTL)
      begin
        rd_data_nxt[tcr_pkg::TCR_BIT_STS_FLUSH] = sts_flush_r;
        rd_data_nxt[tcr_pkg::TCR_BIT_DATA_FLUSH] = data_flush_r;
        rd_data_nxt[tcr_pkg::TCR_BIT_SAO] = sao_r;
        rd_data_nxt[tcr_pkg::TCR_BIT_TX_ON] = tx_on_r;
        rd_data_nxt[tcr_pkg::TCR_BIT_STOP] = stop_r;
      end
      else if (host_addr == tcr_pkg::TCR_OFS_HW_SETUP)
      begin
        rd_data_nxt[tcr_pkg::TCR_BIT_MUST_SET] = must_set_r;
        rd_data_nxt[tcr_pkg::TCR_ALLOC_LSB +: 4] = alloc_r;
        rd_data_nxt[tcr_pkg::TCR_CLKSEL_LSB +: 2] = clksel_r;
      end
    end
  end

  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      sts_flush_r <= 1'b0;
      data_flush_r <= 1'b0;
      sao_r <= 1'b0;
      tx_on_r <= 1'b0;
      stop_r <= 1'b0;
      full_evt_r <= 1'b0;
      must_set_r <= 1'b0;
      alloc_r <= tcr_pkg::TCR_ALLOC_RST;
      clksel_r <= tcr_pkg::TCR_CLKSEL_RST;
      clk_src_r <= tcr_pkg::TCR_CLK_INTERNAL;
      tx_data_bytes_r <= tcr_pkg::TCR_TX_DATA_RST;
      rx_bytes_r <= tcr_pkg::TCR_RX_BYTES_RST;
      rd_data_r <= 32'h0000_0000;
    end
    else
    begin
      sts_flush_r <= sts_flush_nxt;
      data_flush_r <= data_flush_nxt;
      sao_r <= sao_nxt;
      tx_on_r <= tx_on_nxt;
      stop_r <= stop_nxt;
      full_evt_r <= full_evt_nxt;
      must_set_r <= must_set_nxt;
      alloc_r <= alloc_nxt;
      clksel_r <= clksel_nxt;
      clk_src_r <= clk_src_nxt;
      tx_data_bytes_r <= tx_data_bytes_nxt;
      rx_bytes_r <= rx_bytes_nxt;
      rd_data_r <= rd_data_nxt;
    end
  end

  assign host_rd_data = rd_data_r;
  assign tx_run = ctl.run;
  assign tx_stop_req = stop_r;
  assign tx_status_flush = sts_flush_r;
  assign tx_data_flush = data_flush_r;
  assign status_full_event = full_evt_r;
  assign tx_data_bytes = tx_data_bytes_r;
  assign rx_bytes = rx_bytes_r;
  assign must_set_bit = must_set_r;
  assign mii_clock_source = clk_src_r;

  sequence s_flush_pulse_sts;
    tx_status_flush ##1 !tx_status_flush;
  endsequence

  sequence s_flush_pulse_data;
    tx_data_flush ##1 !tx_data_flush;
  endsequence

  property p_sts_flush;
    @(posedge sys_clk) disable iff (reset)
    (ctl_wr && host_wr_data[tcr_pkg::TCR_BIT_STS_FLUSH]) ##1
      !(ctl_wr && host_wr_data[tcr_pkg::TCR_BIT_STS_FLUSH]) |-> s_flush_pulse_sts;
  endproperty
  a_sts_flush: assert property (p_sts_flush) else $error("status flush not a single pulse");

  property p_data_flush;
    @(posedge sys_clk) disable iff (reset)
    (ctl_wr && host_wr_data[tcr_pkg::TCR_BIT_DATA_FLUSH]) ##1
      !(ctl_wr && host_wr_data[tcr_pkg::TCR_BIT_DATA_FLUSH]) |-> s_flush_pulse_data;
  endproperty
  a_data_flush: assert property (p_data_flush) else $error("data flush not a single pulse");

  property p_full_event;
    @(posedge sys_clk) disable iff (reset)
    tx_status_fifo_full |=> status_full_event;
  endproperty
  a_full_event: assert property (p_full_event) else $error("full event missing");

  property p_stop_done;
    @(posedge sys_clk) disable iff (reset)
    (stop_r && tx_halted && !ctl_wr) |=> (!tx_stop_req && !tx_on_r);
  endproperty
  a_stop_done: assert property (p_stop_done) else $error("stop or enable not cleared after halt");

  property p_stop_hold;
    @(posedge sys_clk) disable iff (reset)
    (stop_r && !tx_halted) |=> tx_stop_req;
  endproperty
  a_stop_hold: assert property (p_stop_hold) else $error("stop bit dropped before halt");

  property p_stop_set;
    @(posedge sys_clk) disable iff (reset)
    (ctl_wr && host_wr_data[tcr_pkg::TCR_BIT_STOP] && !stop_r) |=> tx_stop_req;
  endproperty
  a_stop_set: assert property (p_stop_set) else $error("stop request not taken");

  property p_rx_split;
    @(posedge sys_clk) disable iff (reset)
    $stable(alloc_r) |=> (rx_bytes == tcr_pkg::TCR_TOTAL_BYTES - kb_bytes($past(alloc_r)));
  endproperty
  a_rx_split: assert property (p_rx_split) else $error("receive size wrong");

  property p_tx_split;
    @(posedge sys_clk) disable iff (reset)
    $stable(alloc_r) |=> (tx_data_bytes + tcr_pkg::TCR_STATUS_BYTES == kb_bytes($past(alloc_r)));
  endproperty
  a_tx_split: assert property (p_tx_split) else $error("transmit data size wrong");

  property p_clk_decode;
    @(posedge sys_clk) disable iff (reset)
    // table written out, independent of the decode function
    1'b1 |=> (mii_clock_source == (($past(clksel_r) == 2'h1) ? tcr_pkg::TCR_CLK_EXTERNAL :
      (($past(clksel_r) == 2'h2) ? tcr_pkg::TCR_CLK_OFF : tcr_pkg::TCR_CLK_INTERNAL)));
  endproperty
  a_clk_decode: assert property (p_clk_decode) else $error("clock source decode wrong");
endmodule
`default_nettype wire

// *** tb/tcr_tx_model.sv ***
// Purpose: transmitter stand-in driving halted and status full
// Assumes: frames of fixed length, started only while run is granted
// Notes: full level is commanded by the testbench
`timescale 1ns/10ps
`default_nettype none
module tcr_tx_model #(
  parameter int FRAME = 20
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // from the register bank
  input wire logic tx_run,
  input wire logic tx_stop_req,
  input wire logic full_cmd,
  // to the register bank
  output logic tx_halted,
  output logic tx_status_fifo_full,
  output logic [7:0] frames
);
  logic [7:0] cnt_r;
  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      cnt_r <= 8'h00;
      frames <= 8'h00;
    end
    else if (cnt_r != 8'h00)
    begin
      cnt_r <= cnt_r - 8'h01;
      if (cnt_r == 8'h01)
        frames <= frames + 8'h01;
    end
    else if (tx_run && !tx_stop_req)
      cnt_r <= 8'(FRAME);
  end
  // halted only between frames
  assign tx_halted = (cnt_r == 8'h00);
  assign tx_status_fifo_full = full_cmd;
endmodule
`default_nettype wire

// *** tb/testbench.sv ***
// Purpose: self-checking bench for the transmit control register bank
// Assumes: one-cycle host strobes, read data one edge later
// Notes: transmitter model sits on the far side
`timescale 1ns/10ps
`default_nettype none
module testbench;
  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  logic [7:0] host_addr = 8'h00;
  logic host_wr_en = 1'b0;
  logic host_rd_en = 1'b0;
  logic [31:0] host_wr_data = 32'h0;
  logic [31:0] host_rd_data;
  logic full_cmd = 1'b0;
  logic tx_status_fifo_full;
  logic tx_halted;
  logic tx_run;
  logic tx_stop_req;
  logic tx_status_flush;
  logic tx_data_flush;
  logic status_full_event;
  logic must_set_bit;
  logic [14:0] tx_data_bytes;
  logic [14:0] rx_bytes;
  logic [2:0] mii_clock_source;
  logic [7:0] frames;
  int err_count = 0;
  int checked = 0;
  always #10 sys_clk = ~sys_clk;
  tcr_regs dut_u (.sys_clk(sys_clk), .reset(reset), .host_addr(host_addr), .host_wr_en(host_wr_en),
    .host_rd_en(host_rd_en), .host_wr_data(host_wr_data), .host_rd_data(host_rd_data),
    .tx_status_fifo_full(tx_status_fifo_full), .tx_halted(tx_halted), .tx_run(tx_run),
    .tx_stop_req(tx_stop_req), .tx_status_flush(tx_status_flush), .tx_data_flush(tx_data_flush),
    .status_full_event(status_full_event), .tx_data_bytes(tx_data_bytes), .rx_bytes(rx_bytes),
    .must_set_bit(must_set_bit), .mii_clock_source(mii_clock_source));
  tcr_tx_model #(.FRAME(20)) part_u (.sys_clk(sys_clk), .reset(reset), .tx_run(tx_run),
    .tx_stop_req(tx_stop_req), .full_cmd(full_cmd), .tx_halted(tx_halted),
    .tx_status_fifo_full(tx_status_fifo_full), .frames(frames));
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string msg);
    checked++;
    if (got !== exp)
    begin
      err_count++;
      $display("ERROR at %0t: %s got %h expected %h", $time, msg, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    host_addr <= a;
    host_wr_data <= d;
    host_wr_en <= 1'b1;
    @(posedge sys_clk);
    host_wr_en <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge sys_clk);
    host_addr <= a;
    host_rd_en <= 1'b1;
    @(posedge sys_clk);
    host_rd_en <= 1'b0;
    #1;
    d = host_rd_data;
  endtask
  task automatic cycles(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic test_reset();
    logic [31:0] d;
    check({17'h0, tx_data_bytes}, 32'h1200, "data bytes");
    check({17'h0, rx_bytes}, 32'h2c00, "rx bytes");
    check({29'h0, mii_clock_source}, 32'h1, "clock source");
    rd(8'h70, d);
    check(d, 32'h0, "tx control reset");
    rd(8'h74, d);
    check(d, 32'h00050000, "hw setup reset");
    wr(8'h40, 32'hffffffff);
    rd(8'h40, d);
    check(d, 32'h0, "unmapped");
    $display("test reset done");
  endtask
  task automatic test_flush();
    logic [31:0] d;
    wr(8'h70, 32'hffffc000);
    #1;
    check({30'h0, tx_status_flush, tx_data_flush}, 32'h3, "flush pulse");
    cycles(1);
    check({30'h0, tx_status_flush, tx_data_flush}, 32'h0, "flush ends");
    rd(8'h70, d);
    check(d, 32'h0, "flush readback");
    wr(8'h70, 32'h00008000);
    #1;
    check({30'h0, tx_status_flush, tx_data_flush}, 32'h2, "status flush alone");
    wr(8'h70, 32'h00004000);
    #1;
    check({30'h0, tx_status_flush, tx_data_flush}, 32'h1, "data flush alone");
    $display("test flush done");
  endtask
  task automatic test_hw();
    logic [31:0] d;
    logic [2:0] mii[4] = '{3'h1, 3'h2, 3'h4, 3'h1};
    int al;
    // transmitter is idle here; host keeps allocations at 2KB or more
    check({31'h0, tx_run}, 32'h0, "idle before setup");
    for (int i = 0; i < 4; i++)
    begin
      al = 2 + 4 * i;
      wr(8'h74, 32'hffe0ff80 | 32'h00100000 | (al << 16) | (i << 5));
      cycles(2);
      rd(8'h74, d);
      check(d, 32'h00100000 | (al << 16) | (i << 5), "hw readback");
      check({31'h0, must_set_bit}, 32'h1, "must set");
      check({17'h0, tx_data_bytes}, al * 1024 - 512, "data bytes");
      check({17'h0, rx_bytes}, 16384 - al * 1024, "rx bytes");
      check({29'h0, mii_clock_source}, {29'h0, mii[i]}, "clock source");
    end
    $display("test hw done");
  endtask
  task automatic test_sao();
    wr(8'h70, 32'h2);
    cycles(2);
    check({31'h0, tx_run}, 32'h1, "run on");
    @(posedge sys_clk);
    full_cmd <= 1'b1;
    cycles(3);
    check({30'h0, tx_run, status_full_event}, 32'h1, "suspend on full");
    wr(8'h70, 32'h6);
    cycles(2);
    check({30'h0, tx_run, status_full_event}, 32'h3, "overrun allowed");
    @(posedge sys_clk);
    full_cmd <= 1'b0;
    wr(8'h70, 32'h2);
    cycles(2);
    check({30'h0, tx_run, status_full_event}, 32'h2, "full gone");
    $display("test sao done");
  endtask
  task automatic test_stop();
    logic [31:0] d;
    logic [7:0] f0;
    int n;
    // catch a frame right at its start so the stop lands mid-frame
    n = 0;
    while (tx_halted !== 1'b1 && n < 50)
    begin
      cycles(1);
      n++;
    end
    n = 0;
    while (tx_halted !== 1'b0 && n < 50)
    begin
      cycles(1);
      n++;
    end
    check({31'h0, tx_halted}, 32'h0, "frame started");
    f0 = frames;
    wr(8'h70, 32'h3);
    wr(8'h70, 32'h2);
    rd(8'h70, d);
    check(d, 32'h3, "stop write ignored");
    n = 0;
    while (tx_stop_req !== 1'b0 && n < 60)
    begin
      cycles(1);
      n++;
    end
    check({31'h0, tx_stop_req}, 32'h0, "stop cleared");
    check({31'h0, tx_run}, 32'h0, "run off");
    check({24'h0, frames}, {24'h0, f0 + 8'h01}, "frame completed");
    rd(8'h70, d);
    check(d, 32'h0, "stop and enable cleared");
    $display("test stop done");
  endtask
  initial
  begin
    #100000;
    err_count++;
    $display("ERROR at %0t: watchdog expired", $time);
    wrap_up();
  end
  initial
  begin
    repeat (4) @(posedge sys_clk);
    reset <= 1'b0;
    cycles(1);
    test_reset();
    test_flush();
    test_hw();
    test_sao();
    test_stop();
    wrap_up();
  end
endmodule
`default_nettype wire
